// ---- core/ea_stack_map.vh ----
// Constants for the address generation and stack checking unit.
// Assumes a 16-bit data space with byte addressing.
`ifndef EA_STACK_MAP_VH
`define EA_STACK_MAP_VH
`define SP_INDEX 4'hf
`define DEFAULT_REG_INDEX 4'h0
`define STACK_FLOOR 16'h0800
`define FILE_ADDR_BITS 13
`define LIT_SHORT_BITS 5
`define LIT_LONG_BITS 10
`define OFFSET_FIELD_BITS 4
`define MODE_DIRECT 3'h0
`define MODE_INDIRECT 3'h1
`define MODE_POST_MOD 3'h2
`define MODE_PRE_MOD 3'h3
`define MODE_INDEXED 3'h4
`define MODE_LIT_OFFSET 3'h5
`define MODE_FILE 3'h6
`define MODE_LITERAL 3'h7
`define OP_NONE 2'h0
`define OP_PUSH 2'h1
`define OP_POP 2'h2
`define PUSH_DATA 2'h0
`define PUSH_CALL 2'h1
`define PUSH_EXC 2'h2
`endif

// ---- core/reg_file.v ----
// Sixteen-word working register file with two registered read ports.
// Assumes one write per cycle from the address unit.
`timescale 1ns/100ps
`default_nettype none
module reg_file #(
    parameter WIDTH = 16,
    parameter DEPTH = 16,
    parameter ABITS = 4
) (
    // Clock and reset
    input wire core_clk,
    input wire nrst,
    // Write port
    input wire wrEn,
    input wire [ABITS-1:0] wrAddr,
    input wire [WIDTH-1:0] wrData,
    // Read ports
    input wire [ABITS-1:0] rdAddrA,
    input wire [ABITS-1:0] rdAddrB,
    output reg [WIDTH-1:0] rdDataA,
    output reg [WIDTH-1:0] rdDataB
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    integer i;
    always @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            for (i = 0; i < DEPTH; i = i + 1)
                mem[i] <= {WIDTH{1'b0}};
            rdDataA <= {WIDTH{1'b0}};
            rdDataB <= {WIDTH{1'b0}};
        end
        else
        begin
            if (wrEn)
                mem[wrAddr] <= wrData;
            // Reads return the old word when written in the same cycle.
            rdDataA <= mem[rdAddrA];
            rdDataB <= mem[rdAddrB];
        end
    end
endmodule // reg_file
`default_nettype wire

// ---- core/ea_stack_unit.v ----
// Effective address generation, software stack handling and stack/secure RAM checks.
// Assumes the decoder holds a request stable for one cycle and reads results two cycles later.
`timescale 1ns/100ps
`default_nettype none
`include "ea_stack_map.vh"
// Behaviour
// - Register fifteen is stack pointer, grows upward.
// - Pop pre-decrements, push post-increments the pointer.
// - Call push clears program counter upper byte.
// - Exception push joins status byte to counter.
// - Stack limit bit zero always reads zero.
// - Stack pointer addresses compared with stack limit.
// - Push at limit passes; next push traps.
// - Stack pointer below 0x0800 traps underflow.
// - Boot secure RAM only from boot flash.
// - General secure RAM only from secure flash.
// - Direct address field is thirteen bits wide.
// - File instructions use working register zero.
// - First operand register direct; second varies.
// - Arithmetic literals are five or ten bits.
// - Indirect mode uses pointer unchanged.
// - Post-modify uses pointer, then adjusts it.
// - Pre-modify adjusts pointer, then uses it.
// - Indexed adds offset register; literal offset adds literal.
// - Moves add indexed mode, reach whole space.
// - Move source and destination share offset field.
module ea_stack_unit #(
    parameter AW = 16
) (
    // Clock and reset
    input wire core_clk,
    input wire nrst,
    // Address request from the decoder
    input wire reqValid,
    input wire [2:0] addrMode,
    input wire isMove,
    input wire [3:0] ptrSel,
    input wire [3:0] offsetSel,
    input wire [`FILE_ADDR_BITS-1:0] fileAddr,
    input wire [9:0] literalIn,
    input wire longLiteral,
    input wire signed [AW-1:0] modConst,
    input wire [3:0] operand1Sel,
    // Stack operations
    input wire [1:0] stackOp,
    input wire [1:0] pushKind,
    input wire [AW-1:0] pushData,
    input wire [22:0] progCounter,
    input wire [7:0] statusLowByte,
    // Stack limit and register writes
    input wire limitWrEn,
    input wire [AW-1:0] limitWrData,
    input wire regWrEn,
    input wire [3:0] regWrSel,
    input wire [AW-1:0] regWrData,
    // Secure RAM configuration
    input wire bootRamEnable,
    input wire [AW-1:0] bootRamLo,
    input wire [AW-1:0] bootRamHi,
    input wire genRamEnable,
    input wire [AW-1:0] genRamLo,
    input wire [AW-1:0] genRamHi,
    input wire execInBootFlash,
    input wire execInSecureFlash,
    // Results
    output reg [AW-1:0] effAddr,
    output reg effAddrValid,
    output reg [AW-1:0] operand1,
    output reg [AW-1:0] operand2Lit,
    output reg [AW-1:0] pushWord,
    output reg [15:0] pushUpper,
    output reg [3:0] resultRegSel,
    output reg stackErrorTrap,
    output reg accessDenied,
    output reg [AW-1:0] stackLimit,
    output reg [AW-1:0] stackPtr
);
    localparam ST_IDLE = 1'b0;
    localparam ST_ISSUE = 1'b1;

    function inRange;
        input [AW-1:0] a;
        input [AW-1:0] lo;
        input [AW-1:0] hi;
        begin
            inRange = (a >= lo) && (a <= hi);
        end
    endfunction

    // Stage the request while the register file read settles.
    reg state_reg;
    reg [2:0] mode_reg;
    reg move_reg;
    reg [3:0] ptr_reg;
    reg [`FILE_ADDR_BITS-1:0] file_reg;
    reg [9:0] lit_reg;
    reg long_reg;
    reg signed [AW-1:0] mod_reg;
    reg [1:0] op_reg;
    reg [1:0] kind_reg;
    reg [AW-1:0] data_reg;
    reg [22:0] pc_reg;
    reg [7:0] statusLow_reg;
    wire [AW-1:0] ptrVal;
    wire [AW-1:0] offVal;
    wire [AW-1:0] op1Val;
    wire [3:0] rdA;
    wire [3:0] rdB;

    // The register file has one write port; pointer updates from push, pop and pre/post-modify take priority over other writes.
    reg rfWrEn;
    reg [3:0] rfWrSel;
    reg [AW-1:0] rfWrData;
    reg [AW-1:0] eaNext;
    reg [AW-1:0] ptrNext;
    reg ptrUpdate;
    reg [AW-1:0] lit_next;
    reg trap_next;
    reg deny_next;

    // File instructions always read the default working register.
    assign rdA = (addrMode == `MODE_FILE) ? `DEFAULT_REG_INDEX : ptrSel;
    // Port B serves the base offset to indexed moves, else the first operand; one port keeps the file small.
    assign rdB = (addrMode == `MODE_INDEXED && isMove) ? offsetSel : operand1Sel;

    reg_file #(.WIDTH(AW), .DEPTH(16), .ABITS(4)) regs (
        .core_clk(core_clk),
        .nrst(nrst),
        .wrEn(rfWrEn),
        .wrAddr(rfWrSel),
        .wrData(rfWrData),
        .rdAddrA(rdA),
        .rdAddrB(rdB),
        .rdDataA(ptrVal),
        .rdDataB(offVal)
    );
    assign op1Val = offVal;

    always @*
    begin
        eaNext = ptrVal;
        ptrNext = ptrVal;
        ptrUpdate = 1'b0;
        lit_next = {AW{1'b0}};
        trap_next = 1'b0;
        deny_next = 1'b0;
        rfWrEn = regWrEn;
        rfWrSel = regWrSel;
        rfWrData = regWrData;
        if (state_reg == ST_ISSUE)
        begin
            if (op_reg == `OP_PUSH)
            begin
                eaNext = stackPtr;
                ptrNext = stackPtr + 16'h0002;
                ptrUpdate = 1'b1;
            end
            else if (op_reg == `OP_POP)
            begin
                eaNext = stackPtr - 16'h0002;
                ptrNext = eaNext;
                ptrUpdate = 1'b1;
            end
            else
            begin
                case (mode_reg)
                    `MODE_INDIRECT: eaNext = ptrVal;
                    `MODE_POST_MOD:
                    begin
                        eaNext = ptrVal;
                        ptrNext = ptrVal + mod_reg;
                        ptrUpdate = 1'b1;
                    end
                    `MODE_PRE_MOD:
                    begin
                        eaNext = ptrVal + mod_reg;
                        ptrNext = eaNext;
                        ptrUpdate = 1'b1;
                    end
                    // Only moves decode indexed mode; others fall back to plain indirect.
                    `MODE_INDEXED: eaNext = move_reg ? ptrVal + offVal : ptrVal;
                    `MODE_LIT_OFFSET: eaNext = ptrVal + {{6{lit_reg[9]}}, lit_reg};
                    `MODE_FILE: eaNext = {3'h0, file_reg};
                    `MODE_LITERAL:
                    begin
                        eaNext = {AW{1'b0}};
                        lit_next = long_reg ? {6'h00, lit_reg} : {11'h000, lit_reg[4:0]};
                    end
                    default: eaNext = ptrVal;
                endcase
            end
            // Stack pointer addresses check both bounds; at-limit push passes, next one traps.
            // Pops are held to the same two bounds as pushes.
            if ((op_reg != `OP_NONE) || (ptr_reg == `SP_INDEX && mode_reg != `MODE_FILE &&
                mode_reg != `MODE_LITERAL && mode_reg != `MODE_DIRECT))
            begin
                if (eaNext > stackLimit)
                    trap_next = 1'b1;
                if (eaNext < `STACK_FLOOR)
                    trap_next = 1'b1;
            end
            if (bootRamEnable && inRange(eaNext, bootRamLo, bootRamHi) && !execInBootFlash)
                deny_next = 1'b1;
            if (genRamEnable && inRange(eaNext, genRamLo, genRamHi) && !execInSecureFlash)
                deny_next = 1'b1;
            if (ptrUpdate)
            begin
                rfWrEn = 1'b1;
                rfWrSel = (op_reg != `OP_NONE) ? `SP_INDEX : ptr_reg;
                rfWrData = ptrNext;
            end
        end
    end

    always @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_reg <= ST_IDLE;
            mode_reg <= 3'h0;
            move_reg <= 1'b0;
            ptr_reg <= 4'h0;
            file_reg <= {`FILE_ADDR_BITS{1'b0}};
            lit_reg <= 10'h000;
            long_reg <= 1'b0;
            mod_reg <= {AW{1'b0}};
            op_reg <= `OP_NONE;
            kind_reg <= `PUSH_DATA;
            data_reg <= {AW{1'b0}};
            pc_reg <= 23'h000000;
            statusLow_reg <= 8'h00;
            effAddr <= {AW{1'b0}};
            effAddrValid <= 1'b0;
            operand1 <= {AW{1'b0}};
            operand2Lit <= {AW{1'b0}};
            pushWord <= {AW{1'b0}};
            pushUpper <= 16'h0000;
            resultRegSel <= 4'h0;
            stackErrorTrap <= 1'b0;
            accessDenied <= 1'b0;
            // The limit has no documented reset value; zero is used so it is defined.
            stackLimit <= {AW{1'b0}};
            stackPtr <= {AW{1'b0}};
        end
        else
        begin
            state_reg <= reqValid ? ST_ISSUE : ST_IDLE;
            if (reqValid)
            begin
                mode_reg <= addrMode;
                move_reg <= isMove;
                ptr_reg <= ptrSel;
                file_reg <= fileAddr;
                lit_reg <= literalIn;
                long_reg <= longLiteral;
                mod_reg <= modConst;
                op_reg <= stackOp;
                kind_reg <= pushKind;
                data_reg <= pushData;
                pc_reg <= progCounter;
                statusLow_reg <= statusLowByte;
            end
            if (limitWrEn)
                stackLimit <= {limitWrData[AW-1:1], 1'b0};
            // A plain register write to the stack pointer also moves the shadow copy.
            if (rfWrEn && rfWrSel == `SP_INDEX)
                stackPtr <= {rfWrData[AW-1:1], 1'b0};
            effAddrValid <= (state_reg == ST_ISSUE);
            stackErrorTrap <= trap_next;
            accessDenied <= deny_next;
            if (state_reg == ST_ISSUE)
            begin
                effAddr <= eaNext;
                operand1 <= op1Val;
                operand2Lit <= lit_next;
                resultRegSel <= (mode_reg == `MODE_FILE) ? `DEFAULT_REG_INDEX : ptr_reg;
                case (kind_reg)
                    `PUSH_CALL:
                    begin
                        pushWord <= pc_reg[15:0];
                        // Call pushes keep the upper byte clear so a return never sees stale bits.
                        pushUpper <= {8'h00, 1'b0, pc_reg[22:16]};
                    end
                    `PUSH_EXC:
                    begin
                        pushWord <= pc_reg[15:0];
                        // The status byte rides above the counter's top bits so a return restores both.
                        pushUpper <= {statusLow_reg, 1'b0, pc_reg[22:16]};
                    end
                    default:
                    begin
                        pushWord <= data_reg;
                        pushUpper <= 16'h0000;
                    end
                endcase
            end
        end
    end
endmodule // ea_stack_unit
`default_nettype wire

// ---- dv/stack_mem_model.sv ----
// Data memory model on the far side of the stack unit.
// Assumes a push shows as a result whose new pointer is the address plus two.
`timescale 1ns/100ps
`default_nettype none
module stack_mem_model (
    // Clock
    input wire logic core_clk,
    // Results of the unit
    input wire logic effAddrValid,
    input wire logic [15:0] effAddr,
    input wire logic [15:0] stackPtr,
    input wire logic [15:0] pushWord,
    // Read back
    output logic [15:0] rdWord
);
    logic [15:0] mem [0:63];
    always @(posedge core_clk)
    begin
        if (effAddrValid && stackPtr == effAddr + 16'h0002)
            mem[effAddr[6:1]] <= pushWord;
    end
    // Unwritten words stay unknown, so a pop never reads a friendly value.
    assign rdWord = mem[effAddr[6:1]];
endmodule // stack_mem_model
`default_nettype wire

// ---- dv/ea_stack_props_properties.sv ----
// Port checks for the address and stack unit.
// Assumes stack requests are spaced by one result and the limit is at least 0x0800.
`timescale 1ns/100ps
`default_nettype none
module ea_stack_props (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Watched ports
    input wire logic reqValid,
    input wire logic [1:0] stackOp,
    input wire logic effAddrValid,
    input wire logic [15:0] effAddr,
    input wire logic stackErrorTrap,
    input wire logic accessDenied,
    input wire logic [15:0] stackLimit,
    input wire logic [15:0] stackPtr
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    // A literal result leaves the address at zero, so the request kind is tracked, not guessed from the pointer.
    logic [1:0] opDly1_reg;
    logic [1:0] opDly2_reg;
    always @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            opDly1_reg <= 2'h0;
            opDly2_reg <= 2'h0;
        end
        else
        begin
            opDly1_reg <= reqValid ? stackOp : 2'h0;
            opDly2_reg <= opDly1_reg;
        end
    end
    wire pushDone = effAddrValid && opDly2_reg == 2'h1;
    wire popDone = effAddrValid && opDly2_reg == 2'h2;
    property p_answer; reqValid && stackOp != 2'h0 |-> ##[2:3] effAddrValid; endproperty
    a_answer: assert property (p_answer) else $error("no stack address");
    property p_lim_even; stackLimit[0] == 1'b0; endproperty
    a_lim_even: assert property (p_lim_even) else $error("odd limit");
    property p_ptr_even; stackPtr[0] == 1'b0; endproperty
    a_ptr_even: assert property (p_ptr_even) else $error("odd pointer");
    property p_push_post; pushDone |-> effAddr == $past(stackPtr); endproperty
    a_push_post: assert property (p_push_post) else $error("push address");
    property p_pop_pre; popDone |-> stackPtr == $past(stackPtr) - 16'h0002; endproperty
    a_pop_pre: assert property (p_pop_pre) else $error("pop address");
    property p_over; pushDone && effAddr > stackLimit |-> stackErrorTrap; endproperty
    a_over: assert property (p_over) else $error("no overflow trap");
    property p_at_lim; pushDone && effAddr == stackLimit |-> !stackErrorTrap; endproperty
    a_at_lim: assert property (p_at_lim) else $error("trap at limit");
    property p_under; (pushDone || popDone) && effAddr < 16'h0800 |-> stackErrorTrap; endproperty
    a_under: assert property (p_under) else $error("no underflow trap");
    property p_trap; stackErrorTrap |-> effAddrValid ##1 !stackErrorTrap; endproperty
    a_trap: assert property (p_trap) else $error("trap not a pulse");
    property p_deny; accessDenied |-> effAddrValid ##1 !accessDenied; endproperty
    a_deny: assert property (p_deny) else $error("deny not a pulse");
    c_over: cover property (pushDone && stackErrorTrap);
    c_pop: cover property (popDone);
    c_deny: cover property (accessDenied);
endmodule // ea_stack_props
bind ea_stack_unit ea_stack_props u_ea_stack_props (.core_clk(core_clk), .nrst(nrst), .reqValid(reqValid),
    .stackOp(stackOp), .effAddrValid(effAddrValid), .effAddr(effAddr), .stackErrorTrap(stackErrorTrap),
    .accessDenied(accessDenied), .stackLimit(stackLimit), .stackPtr(stackPtr));
`default_nettype wire

// ---- dv/ea_stack_unit_test.sv ----
// Self-checking bench for the address and stack unit.
// Assumes results arrive two cycles after a request, as the unit promises.
`timescale 1ns/100ps
`default_nettype none
module ea_stack_unit_test;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic reqValid = 1'b0, isMove = 1'b0, longLiteral = 1'b0, limitWrEn = 1'b0, regWrEn = 1'b0;
    logic bootOn = 1'b0, genOn = 1'b0, inBoot = 1'b0, inSecure = 1'b0;
    logic [2:0] addrMode = 3'h0;
    logic [3:0] ptrSel = 4'h0, offsetSel = 4'h0, regWrSel = 4'h0, operand1Sel = 4'h0;
    logic [1:0] stackOp = 2'h0, pushKind = 2'h0;
    logic [12:0] fileAddr = 13'h0000;
    logic [9:0] literalIn = 10'h000;
    logic [15:0] modConst = 16'h0000, pushData = 16'h0000, limitWrData = 16'h0000, regWrData = 16'h0000;
    logic [22:0] progCounter = 23'h000000;
    logic [7:0] statusLowByte = 8'h00;
    logic [15:0] ea, tr, dn;
    wire [15:0] effAddr, operand1, operand2Lit, pushWord, stackLimit, stackPtr, rdWord;
    wire [15:0] pushUpper;
    wire [3:0] resultRegSel;
    wire effAddrValid, stackErrorTrap, accessDenied;
    integer fail_count = 0, n_compared = 0;
    always #5 core_clk = ~core_clk;
    ea_stack_unit u_ea_stack_unit (.core_clk(core_clk), .nrst(nrst), .reqValid(reqValid), .addrMode(addrMode),
        .isMove(isMove), .ptrSel(ptrSel), .offsetSel(offsetSel), .fileAddr(fileAddr), .literalIn(literalIn),
        .longLiteral(longLiteral), .modConst(modConst), .operand1Sel(operand1Sel), .stackOp(stackOp),
        .pushKind(pushKind), .pushData(pushData), .progCounter(progCounter), .statusLowByte(statusLowByte),
        .limitWrEn(limitWrEn), .limitWrData(limitWrData), .regWrEn(regWrEn), .regWrSel(regWrSel),
        .regWrData(regWrData), .bootRamEnable(bootOn), .bootRamLo(16'h1000), .bootRamHi(16'h10ff),
        .genRamEnable(genOn), .genRamLo(16'h1000), .genRamHi(16'h10ff), .execInBootFlash(inBoot),
        .execInSecureFlash(inSecure), .effAddr(effAddr), .effAddrValid(effAddrValid), .operand1(operand1),
        .operand2Lit(operand2Lit), .pushWord(pushWord), .pushUpper(pushUpper), .resultRegSel(resultRegSel),
        .stackErrorTrap(stackErrorTrap), .accessDenied(accessDenied), .stackLimit(stackLimit),
        .stackPtr(stackPtr));
    stack_mem_model u_stack_mem_model (.core_clk(core_clk), .effAddrValid(effAddrValid), .effAddr(effAddr),
        .stackPtr(stackPtr), .pushWord(pushWord), .rdWord(rdWord));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic step;
        @(posedge core_clk);
        #1;
    endtask
    task automatic wr(input logic [3:0] r, input logic [15:0] d);
        step;
        regWrEn = 1'b1;
        regWrSel = r;
        regWrData = d;
        step;
        regWrEn = 1'b0;
    endtask
    // Literal requests are timed by the fixed latency instead of the valid pulse.
    task automatic req(input logic [2:0] m, input logic [3:0] p, input logic [1:0] op);
        integer i;
        step;
        addrMode = m;
        ptrSel = p;
        stackOp = op;
        reqValid = 1'b1;
        step;
        reqValid = 1'b0;
        stackOp = 2'h0;
        for (i = 0; i < 8 && effAddrValid !== 1'b1 && m != 3'h7; i++)
            step;
        if (i == 8)
        begin
            fail_count++;
            wrap_up;
        end
        repeat ((m == 3'h7) ? 3 : 0) step;
        ea = effAddr;
        tr = {15'h0000, stackErrorTrap};
        dn = {15'h0000, accessDenied};
    endtask
    task automatic t_modes;
        chk(stackLimit, 16'h0000);
        wr(4'h3, 16'h1234);
        wr(4'h4, 16'h0010);
        operand1Sel = 4'h4;
        req(3'h1, 4'h3, 2'h0);
        chk(ea, 16'h1234);
        chk(operand1, 16'h0010);
        modConst = 16'h0002;
        req(3'h2, 4'h3, 2'h0);
        chk(ea, 16'h1234);
        req(3'h1, 4'h3, 2'h0);
        chk(ea, 16'h1236);
        modConst = 16'hfffc;
        req(3'h3, 4'h3, 2'h0);
        chk(ea, 16'h1232);
        offsetSel = 4'h4;
        isMove = 1'b1;
        req(3'h4, 4'h3, 2'h0);
        chk(ea, 16'h1242);
        isMove = 1'b0;
        req(3'h4, 4'h3, 2'h0);
        chk(ea, 16'h1232);
        literalIn = 10'h005;
        req(3'h5, 4'h3, 2'h0);
        chk(ea, 16'h1237);
        fileAddr = 13'h1ffe;
        req(3'h6, 4'h3, 2'h0);
        chk(ea, 16'h1ffe);
        chk({12'h000, resultRegSel}, 16'h0000);
        literalIn = 10'h3ff;
        req(3'h7, 4'h0, 2'h0);
        chk(operand2Lit, 16'h001f);
        longLiteral = 1'b1;
        req(3'h7, 4'h0, 2'h0);
        chk(operand2Lit, 16'h03ff);
        $display("addressing modes test done");
    endtask
    task automatic t_stack;
        step;
        limitWrEn = 1'b1;
        limitWrData = 16'h0903;
        step;
        limitWrEn = 1'b0;
        step;
        chk(stackLimit, 16'h0902);
        wr(4'hf, 16'h0900);
        pushData = 16'h1357;
        req(3'h0, 4'hf, 2'h1);
        chk(ea, 16'h0900);
        chk(stackPtr, 16'h0902);
        chk(tr, 16'h0000);
        req(3'h0, 4'hf, 2'h1);
        chk(tr, 16'h0000);
        pushData = 16'habcd;
        req(3'h0, 4'hf, 2'h1);
        chk(tr, 16'h0001);
        chk(stackPtr, 16'h0906);
        req(3'h1, 4'hf, 2'h0);
        chk(ea, 16'h0906);
        chk(tr, 16'h0001);
        req(3'h0, 4'hf, 2'h2);
        chk(ea, 16'h0904);
        chk(rdWord, 16'habcd);
        wr(4'hf, 16'h0800);
        req(3'h0, 4'hf, 2'h2);
        chk(ea, 16'h07fe);
        chk(tr, 16'h0001);
        pushKind = 2'h1;
        progCounter = 23'h7a5678;
        req(3'h0, 4'hf, 2'h1);
        chk(pushWord, 16'h5678);
        chk(pushUpper, 16'h007a);
        pushKind = 2'h2;
        statusLowByte = 8'h5c;
        req(3'h0, 4'hf, 2'h1);
        chk(pushUpper, 16'h5c7a);
        chk(pushWord, 16'h5678);
        $display("stack test done");
    endtask
    task automatic t_secure;
        wr(4'h5, 16'h1010);
        bootOn = 1'b1;
        req(3'h1, 4'h5, 2'h0);
        chk(dn, 16'h0001);
        inBoot = 1'b1;
        req(3'h1, 4'h5, 2'h0);
        chk(dn, 16'h0000);
        bootOn = 1'b0;
        genOn = 1'b1;
        req(3'h1, 4'h5, 2'h0);
        chk(dn, 16'h0001);
        inSecure = 1'b1;
        req(3'h1, 4'h5, 2'h0);
        chk(dn, 16'h0000);
        $display("secure RAM test done");
    endtask
    initial
    begin
        repeat (5) @(posedge core_clk);
        #1 nrst = 1'b1;
        t_modes;
        t_stack;
        t_secure;
        wrap_up;
    end
endmodule // ea_stack_unit_test
`default_nettype wire
